/* tb_top.sv */
// tb_top: self-checking bench for the extended register decode
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  // ==========================================
  // signals
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic soft_rst = 1'b0;
  uxr_pkg::uxr_bus_t host = '0;
  logic rd_valid;
  logic [7:0] rd_data;
  uxr_pkg::uxr_bus_t std_req;
  logic [7:0] std_rdata;
  logic [7:0] rx_fill_level = 8'h2c;
  logic [7:0] tx_fill_level = 8'h41;
  logic [7:0] status_in = 8'ha5;
  uxr_pkg::uxr_cfg_t cfg;
  int n_errors = 0;
  int samples_checked = 0;

  always #2 ref_clk = ~ref_clk;

  // ==========================================
  // instances
  uxr_decode uxr_decode_inst (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .soft_rst(soft_rst),
    .host(host),
    .rd_valid(rd_valid),
    .rd_data(rd_data),
    .std_req(std_req),
    .std_rdata(std_rdata),
    .rx_fill_level(rx_fill_level),
    .tx_fill_level(tx_fill_level),
    .status_in(status_in),
    .cfg(cfg)
  );

  uxr_std_model uxr_std_model_inst (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .std_req(std_req),
    .std_rdata(std_rdata)
  );

  // ==========================================
  // tasks
  task automatic complete_run();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    host <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(negedge ref_clk);
    host <= '0;
  endtask : wr

  // bounded wait: the answer is due one edge after the taking edge
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    int i;
    i = 0;
    @(negedge ref_clk);
    host <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(negedge ref_clk);
    host <= '0;
    while (rd_valid !== 1'b1 && i < 4) begin
      @(negedge ref_clk);
      i++;
    end
    chk("rd_valid", 8'h01, {7'h00, rd_valid});
    chk($sformatf("read at %0d", a), exp, rd_data);
  endtask : rd

  // ==========================================
  // watchdog: the sequence needs well under 2 us
  initial begin
    #20000;
    n_errors++;
    complete_run();
  end

  // ==========================================
  // tests
  initial begin
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    rstn <= 1'b1;
    chk("prescale", 8'h20, cfg.idx[1]);
    chk("add_ctrl", 8'h00, cfg.idx[0]);
    chk("line_ctrl", 8'h00, cfg.line_control);
    wr(3'h1, 8'h5a);
    rd(3'h1, 8'h5a);
    // compatibility view
    wr(3'h3, 8'hbf);
    wr(3'h2, 8'h11);
    wr(3'h4, 8'h22);
    wr(3'h5, 8'h33);
    wr(3'h6, 8'h44);
    wr(3'h7, 8'h55);
    rd(3'h2, 8'h11);
    rd(3'h4, 8'h22);
    rd(3'h5, 8'h33);
    rd(3'h6, 8'h44);
    rd(3'h7, 8'h55);
    chk("features", 8'h11, cfg.enhanced_features);
    wr(3'h3, 8'h03);
    rd(3'h3, 8'h03);
    rd(3'h2, 8'h12);
    rd(3'h4, 8'h14);
    // window write opens the additional status view
    wr(3'h7, 8'h00);
    wr(3'h5, 8'h80);
    chk("add_ctrl", 8'h80, cfg.idx[0]);
    rd(3'h3, 8'h2c);
    rd(3'h4, 8'h41);
    rd(3'h1, 8'ha4);
    wr(3'h1, 8'hff);
    chk("tx_disable", 8'h03, {6'h00, cfg.tx_disable});
    rd(3'h1, 8'ha7);
    wr(3'h3, 8'h80);
    wr(3'h1, 8'h5a);
    chk("tx_disable", 8'h03, {6'h00, cfg.tx_disable});
    rd(3'h1, 8'h5a);
    wr(3'h3, 8'hbf);
    rd(3'h4, 8'h22);
    wr(3'h3, 8'h03);
    // indexed reads
    wr(3'h5, 8'hc0);
    wr(3'h7, 8'h01);
    rd(3'h5, 8'h20);
    wr(3'h7, 8'h08);
    wr(3'h5, 8'hff);
    rd(3'h5, 8'h5a);
    wr(3'h7, 8'h09);
    rd(3'h5, 8'h3c);
    wr(3'h7, 8'h04);
    wr(3'h5, 8'h10);
    rd(3'h5, 8'h10);
    wr(3'h7, 8'h00);
    wr(3'h5, 8'h80);
    rd(3'h5, 8'h15);
    // soft reset in mid-run
    @(negedge ref_clk);
    soft_rst <= 1'b1;
    @(negedge ref_clk);
    soft_rst <= 1'b0;
    chk("add_ctrl", 8'h00, cfg.idx[0]);
    chk("prescale", 8'h20, cfg.idx[1]);
    chk("tx_thr", 8'h00, cfg.idx[4]);
    chk("line_ctrl", 8'h00, cfg.line_control);
    rd(3'h1, 8'h5a);
    complete_run();
  end
endmodule : tb_top
`default_nettype wire

/* uxr_decode.sv */
// uxr_decode: extended register decode and access gating
`timescale 1ns/10ps
`default_nettype none
//
// Contract
// - compat value in line control opens features and flow chars
// - tx fill level and window decode only when line control is not compat, rx fill level in any
// - additional status mapped only while divisor latch bit clear
// - interrupt enable reachable only while additional status enable clear or divisor latch bit set
// - status, fill levels need additional status enable set
// - line/modem control read back only when enable clear, else fill levels
// - line status read only while indexed-read enable clear
// - window read returns indexed data only while indexed-read enable set
// - host writes to additional status touch only bits 0 and 1
// - window at address 101 forwards to selected indexed register
// - address 011 reads receive fifo character count
// - address 100 reads transmit fifo character count
// - resets load prescale 0x20 and clear other writable registers
module uxr_decode #(
  // arbitrary identification values
  parameter logic [7:0] ID1_VAL = 8'h5a,
  parameter logic [7:0] ID2_VAL = 8'h3c
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic soft_rst,
  // host register port
  input wire uxr_pkg::uxr_bus_t host,
  output logic rd_valid,
  output logic [7:0] rd_data,
  // standard bank
  output uxr_pkg::uxr_bus_t std_req,
  input wire logic [7:0] std_rdata,
  // uart state
  input wire logic [7:0] rx_fill_level,
  input wire logic [7:0] tx_fill_level,
  input wire logic [7:0] status_in,
  // configuration
  output uxr_pkg::uxr_cfg_t cfg
);

  // ==========================================
  // state
  uxr_pkg::uxr_st_t st;
  uxr_pkg::uxr_st_t next_st;
  logic compat;
  logic dlab;
  logic ase;
  logic ire;
  logic asr_map;
  logic idx_wr;
  logic [7:0] idx_rdata;
  logic [uxr_pkg::IDX_NREG-1:0][7:0] idx_regs;

  // ==========================================
  // indexed set
  uxr_index #(
    .ID1_VAL(ID1_VAL),
    .ID2_VAL(ID2_VAL)
  ) u_index (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .soft_rst(soft_rst),
    .wr(idx_wr),
    .offset(st.scratch_pad),
    .wdata(host.wdata),
    .rdata(idx_rdata),
    .regs(idx_regs)
  );

  // ==========================================
  // mode decode
  assign compat = st.line_control == uxr_pkg::LCR_COMPAT;
  assign dlab = st.line_control[uxr_pkg::LCR_DLAB_BIT];
  assign ase = idx_regs[0][uxr_pkg::ACR_ASE_BIT];
  assign ire = idx_regs[0][uxr_pkg::ACR_IRE_BIT];
  // compat value has bit 7 set, so dlab already excludes it
  assign asr_map = !dlab && ase;

  // ==========================================
  // next state
  always_comb begin
    next_st = st;
    idx_wr = 1'b0;
    next_st.std = '0;
    next_st.p_rd = 1'b0;
    next_st.p_std = 1'b0;
    next_st.p_data = uxr_pkg::ZERO8;
    next_st.rd_valid = st.p_rd;
    // read data stands until the next answer replaces it
    if (st.p_rd) begin
      next_st.rd_data = st.p_std ? std_rdata : st.p_data;
    end
    // write side
    if (host.wr) begin
      case (host.addr)
        uxr_pkg::ADR_IER: begin
          if (asr_map) begin
            next_st.tx_disable = host.wdata[1:0];
          end else begin
            next_st.std.wr = 1'b1;
          end
        end
        uxr_pkg::ADR_FCR: begin
          if (compat) begin
            next_st.enhanced_features = host.wdata;
          end else begin
            next_st.std.wr = 1'b1;
          end
        end
        uxr_pkg::ADR_LCR: begin
          next_st.line_control = host.wdata;
        end
        uxr_pkg::ADR_MCR: begin
          if (compat) begin
            next_st.resume_char_1 = host.wdata;
          end else begin
            next_st.std.wr = 1'b1;
          end
        end
        uxr_pkg::ADR_LSR: begin
          if (compat) begin
            next_st.resume_char_2 = host.wdata;
          end else begin
            idx_wr = 1'b1;
          end
        end
        uxr_pkg::ADR_MSR: begin
          if (compat) begin
            next_st.pause_char_1 = host.wdata;
          end else begin
            next_st.std.wr = 1'b1;
          end
        end
        uxr_pkg::ADR_SPR: begin
          if (compat) begin
            next_st.pause_char_2 = host.wdata;
          end else begin
            next_st.scratch_pad = host.wdata;
          end
        end
        default: begin
          next_st.std.wr = 1'b1;
        end
      endcase
    end
    // read side: sample the source now, present it one edge later
    if (host.rd) begin
      next_st.p_rd = 1'b1;
      case (host.addr)
        uxr_pkg::ADR_IER: begin
          if (asr_map) begin
            next_st.p_data = {status_in[7:uxr_pkg::STAT_LO_BIT],
                              st.tx_disable};
          end else begin
            next_st.p_std = 1'b1;
          end
        end
        uxr_pkg::ADR_FCR: begin
          if (compat) begin
            next_st.p_data = st.enhanced_features;
          end else begin
            next_st.p_std = 1'b1;
          end
        end
        uxr_pkg::ADR_LCR: begin
          if (ase) begin
            next_st.p_data = rx_fill_level;
          end else begin
            next_st.p_data = st.line_control;
          end
        end
        uxr_pkg::ADR_MCR: begin
          if (compat) begin
            next_st.p_data = st.resume_char_1;
          end else if (ase) begin
            next_st.p_data = tx_fill_level;
          end else begin
            next_st.p_std = 1'b1;
          end
        end
        uxr_pkg::ADR_LSR: begin
          if (compat) begin
            next_st.p_data = st.resume_char_2;
          end else if (ire) begin
            next_st.p_data = idx_rdata;
          end else begin
            next_st.p_std = 1'b1;
          end
        end
        uxr_pkg::ADR_MSR: begin
          if (compat) begin
            next_st.p_data = st.pause_char_1;
          end else begin
            next_st.p_std = 1'b1;
          end
        end
        uxr_pkg::ADR_SPR: begin
          if (compat) begin
            next_st.p_data = st.pause_char_2;
          end else begin
            next_st.p_data = st.scratch_pad;
          end
        end
        default: begin
          next_st.p_std = 1'b1;
        end
      endcase
      next_st.std.rd = next_st.p_std;
    end
    if (next_st.std.rd || next_st.std.wr) begin
      next_st.std.addr = host.addr;
      next_st.std.wdata = host.wdata;
    end
  end

  // soft reset acts exactly like the pin reset here
  always_ff @(posedge ref_clk) begin
    if (!rstn || soft_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================
  // outputs
  assign rd_valid = st.rd_valid;
  assign rd_data = st.rd_data;
  assign std_req = st.std;
  assign cfg = '{line_control: st.line_control, enhanced_features: st.enhanced_features,
                 resume_char_1: st.resume_char_1, resume_char_2: st.resume_char_2, pause_char_1: st.pause_char_1,
                 pause_char_2: st.pause_char_2, tx_disable: st.tx_disable,
                 idx: idx_regs};

  // ==========================================
  // checks
  property p_efr_wr;
    @(posedge ref_clk) disable iff (!rstn || soft_rst)
      host.wr && host.addr == uxr_pkg::ADR_FCR && compat
      |=> st.enhanced_features == $past(host.wdata) && !std_req.wr;
  endproperty
  a_efr_wr: assert property (p_efr_wr) else $error("features write lost");

  property p_no_win_compat;
    @(posedge ref_clk) disable iff (!rstn)
      compat |-> !idx_wr;
  endproperty
  a_no_win_compat: assert property (p_no_win_compat) else $error("window open in compat");

  property p_asr_dlab;
    @(posedge ref_clk) disable iff (!rstn || soft_rst)
      host.wr && host.addr == uxr_pkg::ADR_IER && dlab
      |=> $stable(st.tx_disable) && std_req.wr;
  endproperty
  a_asr_dlab: assert property (p_asr_dlab) else $error("status hit with dlab");

  property p_ier_fwd;
    @(posedge ref_clk) disable iff (!rstn || soft_rst)
      host.rd && host.addr == uxr_pkg::ADR_IER && !ase
      |=> std_req.rd && std_req.addr == uxr_pkg::ADR_IER ##1 rd_data == $past(std_rdata);
  endproperty
  a_ier_fwd: assert property (p_ier_fwd) else $error("ier not forwarded");

  property p_rfl;
    @(posedge ref_clk) disable iff (!rstn || soft_rst)
      host.rd && host.addr == uxr_pkg::ADR_LCR && ase
      |-> ##2 rd_valid && rd_data == $past(rx_fill_level, 2);
  endproperty
  a_rfl: assert property (p_rfl) else $error("rx fill wrong");

  property p_lcr_rd;
    @(posedge ref_clk) disable iff (!rstn || soft_rst)
      host.rd && !host.wr && host.addr == uxr_pkg::ADR_LCR && !ase
      |-> ##2 rd_valid && rd_data == $past(st.line_control, 2);
  endproperty
  a_lcr_rd: assert property (p_lcr_rd) else $error("lcr read wrong");

  property p_tfl;
    @(posedge ref_clk) disable iff (!rstn || soft_rst)
      host.rd && host.addr == uxr_pkg::ADR_MCR && ase && !compat
      |-> ##2 rd_data == $past(tx_fill_level, 2);
  endproperty
  a_tfl: assert property (p_tfl) else $error("tx fill wrong");

  property p_lsr_fwd;
    @(posedge ref_clk) disable iff (!rstn || soft_rst)
      host.rd && host.addr == uxr_pkg::ADR_LSR && !ire && !compat
      |=> std_req.rd;
  endproperty
  a_lsr_fwd: assert property (p_lsr_fwd) else $error("lsr not forwarded");

  property p_win_rd;
    @(posedge ref_clk) disable iff (!rstn || soft_rst)
      host.rd && host.addr == uxr_pkg::ADR_LSR && ire && !compat
      |-> ##2 rd_data == $past(idx_rdata, 2) && !$past(std_req.rd);
  endproperty
  a_win_rd: assert property (p_win_rd) else $error("window read wrong");

  property p_asr_mask;
    @(posedge ref_clk) disable iff (!rstn || soft_rst)
      host.wr && host.addr == uxr_pkg::ADR_IER && asr_map
      |=> st.tx_disable == $past(host.wdata[1:0]) && !std_req.wr;
  endproperty
  a_asr_mask: assert property (p_asr_mask) else $error("status write mask");

  property p_win_wr;
    @(posedge ref_clk) disable iff (!rstn || soft_rst)
      host.wr && host.addr == uxr_pkg::ADR_LSR && !compat
      && st.scratch_pad == uxr_pkg::IDX_TTL
      |=> idx_regs[4] == $past(host.wdata);
  endproperty
  a_win_wr: assert property (p_win_wr) else $error("window write lost");

  c_compat: cover property (@(posedge ref_clk) compat && host.wr);
  c_win_rd: cover property (@(posedge ref_clk) host.rd && ire && !compat);
  c_fill: cover property (@(posedge ref_clk) host.rd && ase && host.addr == uxr_pkg::ADR_MCR);

endmodule : uxr_decode
`default_nettype wire

/* uxr_index.sv */
// uxr_index: indexed control register set behind the window
`timescale 1ns/10ps
`default_nettype none
module uxr_index #(
  // arbitrary identification values
  parameter logic [7:0] ID1_VAL = 8'h5a,
  parameter logic [7:0] ID2_VAL = 8'h3c
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic soft_rst,
  // window access
  input wire logic wr,
  input wire logic [7:0] offset,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  // register contents
  output logic [uxr_pkg::IDX_NREG-1:0][7:0] regs
);

  // ==========================================
  // state
  uxr_pkg::uxr_idx_st_t st;
  uxr_pkg::uxr_idx_st_t next_st;
  logic [uxr_pkg::IDX_NREG-1:0] wen;

  genvar gi;
  generate
    for (gi = 0; gi < uxr_pkg::IDX_NREG; gi++) begin : g_wen
      assign wen[gi] = wr && (offset == 8'(gi));
    end
  endgenerate

  always_comb begin
    next_st = st;
    for (int i = 0; i < uxr_pkg::IDX_NREG; i++) begin
      if (wen[i]) begin
        next_st.regs[i] = wdata;
      end
    end
  end

  // both resets restore the table, prescale included
  always_ff @(posedge ref_clk) begin
    if (!rstn || soft_rst) begin
      st <= '{regs: uxr_pkg::IDX_RST_VAL};
    end else begin
      st <= next_st;
    end
  end

  // ==========================================
  // read side; ids are constants, writes to them fall through
  always_comb begin
    if (offset < 8'(uxr_pkg::IDX_NREG)) begin
      rdata = st.regs[offset[2:0]];
    end else if (offset == uxr_pkg::IDX_ID1) begin
      rdata = ID1_VAL;
    end else if (offset == uxr_pkg::IDX_ID2) begin
      rdata = ID2_VAL;
    end else begin
      rdata = uxr_pkg::ZERO8;
    end
  end

  assign regs = st.regs;

  property p_cpr_reset;
    @(posedge ref_clk) !rstn |=> regs[1] == uxr_pkg::CPR_RST;
  endproperty
  a_cpr_reset: assert property (p_cpr_reset) else $error("prescale not reset");

  property p_id_const;
    @(posedge ref_clk) disable iff (!rstn)
      offset == uxr_pkg::IDX_ID1 |-> rdata == ID1_VAL;
  endproperty
  a_id_const: assert property (p_id_const) else $error("id byte wrong");

endmodule : uxr_index
`default_nettype wire

/* uxr_pkg.sv */
// uxr_pkg: shared constants and types for the extended register decode
package uxr_pkg;

  // ==========================================
  // host addresses, standard view
  localparam logic [2:0] ADR_DATA = 3'h0;
  localparam logic [2:0] ADR_IER = 3'h1;
  localparam logic [2:0] ADR_FCR = 3'h2;
  localparam logic [2:0] ADR_LCR = 3'h3;
  localparam logic [2:0] ADR_MCR = 3'h4;
  localparam logic [2:0] ADR_LSR = 3'h5;
  localparam logic [2:0] ADR_MSR = 3'h6;
  localparam logic [2:0] ADR_SPR = 3'h7;

  // ==========================================
  // control values and bit positions
  localparam logic [7:0] LCR_COMPAT = 8'hbf;
  localparam int LCR_DLAB_BIT = 7;
  localparam int ACR_ASE_BIT = 7;
  localparam int ACR_IRE_BIT = 6;
  localparam int STAT_LO_BIT = 2;
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam logic [7:0] CPR_RST = 8'h20;

  // ==========================================
  // indexed offsets
  localparam logic [7:0] IDX_ACR = 8'h00;
  localparam logic [7:0] IDX_CPR = 8'h01;
  localparam logic [7:0] IDX_TCR = 8'h02;
  localparam logic [7:0] IDX_CKS = 8'h03;
  localparam logic [7:0] IDX_TTL = 8'h04;
  localparam logic [7:0] IDX_RTL = 8'h05;
  localparam logic [7:0] IDX_FCL = 8'h06;
  localparam logic [7:0] IDX_FCH = 8'h07;
  localparam logic [7:0] IDX_ID1 = 8'h08;
  localparam logic [7:0] IDX_ID2 = 8'h09;
  localparam int IDX_NREG = 8;
  localparam logic [IDX_NREG-1:0][7:0] IDX_RST_VAL =
    {ZERO8, ZERO8, ZERO8, ZERO8, ZERO8, ZERO8, CPR_RST, ZERO8};

  // ==========================================
  // carriers
  typedef struct packed {
    logic rd;
    logic wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } uxr_bus_t;

  typedef struct packed {
    logic [7:0] line_control;
    logic [7:0] enhanced_features;
    logic [7:0] resume_char_1;
    logic [7:0] resume_char_2;
    logic [7:0] pause_char_1;
    logic [7:0] pause_char_2;
    logic [1:0] tx_disable;
    logic [IDX_NREG-1:0][7:0] idx;
  } uxr_cfg_t;

  typedef struct packed {
    logic [7:0] line_control;
    logic [7:0] scratch_pad;
    logic [7:0] enhanced_features;
    logic [7:0] resume_char_1;
    logic [7:0] resume_char_2;
    logic [7:0] pause_char_1;
    logic [7:0] pause_char_2;
    logic [1:0] tx_disable;
    uxr_bus_t std;
    logic p_rd;
    logic p_std;
    logic [7:0] p_data;
    logic rd_valid;
    logic [7:0] rd_data;
  } uxr_st_t;

  typedef struct packed {
    logic [IDX_NREG-1:0][7:0] regs;
  } uxr_idx_st_t;

endpackage : uxr_pkg

/* uxr_std_model.sv */
// uxr_std_model: behavioural standard register bank on the forwarded port
`timescale 1ns/10ps
`default_nettype none
module uxr_std_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // forwarded access
  input wire uxr_pkg::uxr_bus_t std_req,
  output logic [7:0] std_rdata
);
  // ==========================================
  // storage
  logic [7:0] mem [8];
  logic [7:0] last;

  // preset pattern so a forwarded read is told apart from a local one
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      for (int i = 0; i < 8; i++) begin
        mem[i] <= 8'h10 + 8'(i);
      end
      last <= 8'h00;
    end else begin
      if (std_req.wr) begin
        mem[std_req.addr] <= std_req.wdata;
      end
      if (std_req.rd) begin
        last <= mem[std_req.addr];
      end
    end
  end

  // released bus shows the inverse of the last value, never a stale copy
  always_comb std_rdata = std_req.rd ? mem[std_req.addr] : ~last;
endmodule : uxr_std_model
`default_nettype wire
